// ==== core/strap_pkg.sv ====
// Purpose: Shared constants for the power-up clock ratio strap decoder
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Core and memory clock ratios are given as numerator and denominator pairs
package strap_pkg;
  // Register byte offset of the lane power control word
  localparam logic [19:0] LANE_PWR_OFFSET = 20'he0f08;
  // Register byte offset of the strap status word
  localparam logic [19:0] STRAP_STAT_OFFSET = 20'he0f0c;
  // Value after reset of the lane power control field
  localparam logic [7:0] LANE_PWR_RESET = 8'h00;
  // Field positions in the strap status word
  localparam int STAT_PLAT_LSB = 0;
  localparam int STAT_CORE_LSB = 4;
  localparam int STAT_SRDS_BIT = 7;
  localparam int STAT_PLAT_BAD = 8;
  localparam int STAT_CORE_BAD = 9;
  localparam int STAT_CAPT_BIT = 10;
  // Strap synchroniser depth in flip-flops
  localparam int SYNC_STAGES = 3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== core/axil_if.sv ====
// Purpose: AXI4-Lite signal bundle between the top and its bus slave
// Assumes: 32-bit data, 20-bit byte address
// Notes:   Slave modport drives ready, valid of responses and read data
`timescale 1ns/1ps
`default_nettype none
interface axil_if;
  logic [19:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [19:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  modport slave (
    input  awaddr, awvalid, wdata, wstrb, wvalid, bready,
    input  araddr, arvalid, rready,
    output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
  );
  modport master (
    output awaddr, awvalid, wdata, wstrb, wvalid, bready,
    output araddr, arvalid, rready,
    input  awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
  );
endinterface
`default_nettype wire

// ==== core/axil_regs.sv ====
// Purpose: AXI4-Lite slave holding lane power control and strap status
// Assumes: One write and one read under way at a time
// Notes:   Unmapped addresses answer SLVERR, reads of them return zero
`timescale 1ns/1ps
`default_nettype none
module axil_regs (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  axil_if.slave            bus,
  input  wire logic [31:0] status_in,
  output logic      [7:0]  lane_pwr_out
);
  logic [19:0] awaddr_r;
  logic        aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_have_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic [7:0]  lane_pwr_r;

  // Ready while the slot is empty and no response is pending
  assign bus.awready = !aw_have_r && !bvalid_r;
  assign bus.wready  = !w_have_r && !bvalid_r;
  assign bus.arready = !rvalid_r;
  assign bus.bvalid  = bvalid_r;
  assign bus.bresp   = bresp_r;
  assign bus.rvalid  = rvalid_r;
  assign bus.rresp   = rresp_r;
  assign bus.rdata   = rdata_r;
  assign lane_pwr_out = lane_pwr_r;

  // Write address and data capture in either order, then respond
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= strap_pkg::RESP_OKAY;
    end else begin
      if (bus.awvalid && bus.awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= bus.awaddr;
      end
      if (bus.wvalid && bus.wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= bus.wdata;
        wstrb_r  <= bus.wstrb;
      end
      if (aw_have_r && w_have_r) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (awaddr_r == strap_pkg::LANE_PWR_OFFSET) ?
                     strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
      end else if (bvalid_r && bus.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Lane power field, byte lane 0 only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lane_pwr_r <= strap_pkg::LANE_PWR_RESET;
    end else if (aw_have_r && w_have_r && wstrb_r[0]
                 && awaddr_r == strap_pkg::LANE_PWR_OFFSET) begin
      lane_pwr_r <= wdata_r[7:0];
    end
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rvalid_r <= 1'b0;
      rresp_r  <= strap_pkg::RESP_OKAY;
      rdata_r  <= '0;
    end else if (bus.arvalid && bus.arready) begin
      rvalid_r <= 1'b1;
      if (bus.araddr == strap_pkg::LANE_PWR_OFFSET) begin
        rdata_r <= {24'h000000, lane_pwr_r};
        rresp_r <= strap_pkg::RESP_OKAY;
      end else if (bus.araddr == strap_pkg::STRAP_STAT_OFFSET) begin
        rdata_r <= status_in;
        rresp_r <= strap_pkg::RESP_OKAY;
      end else begin
        rdata_r <= '0;
        rresp_r <= strap_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && bus.rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== core/strap_decoder.sv ====
// Overview of operation
// - Platform clock ratio over the reference clock comes from four platform straps caught at power-up.
// - Platform codes 0000,0010-0110,1000,1001,1010,1100,1101 give 16,2-6,8,9,10,12,20 to one.
// - Core over platform ratio comes from bus-control, address-latch and gp-line straps at power-up.
// - Core codes 000,001,011,100,101,110,111 give 4:1,9:2,3:2,2:1,5:2,3:1,7:2.
// - On revision 2.0 parts the serial-enable strap can power down the whole transceiver block.
// - The memory bus clock runs at half the platform clock.
//
// Purpose: Decode power-up straps into clock ratios and serial power-down
// Assumes: clk_in is the reference input clock domain; straps are pins
// Notes:   Reserved codes give a zero ratio and raise a flag
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module strap_decoder #(
  parameter bit REV2_PART = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [3:0]  platform_ratio_straps_in,
  input  wire logic        core_ratio_strap_bus_control_in,
  input  wire logic        core_ratio_strap_addr_latch_in,
  input  wire logic        core_ratio_strap_gp_line_in,
  input  wire logic        serial_enable_strap_in,
  input  wire logic [19:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic      [1:0]  s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [19:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic      [31:0] s_axi_rdata_out,
  output logic      [1:0]  s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic      [4:0]  platform_mult_out,
  output logic      [3:0]  core_mult_num_out,
  output logic      [1:0]  core_mult_den_out,
  output logic      [5:0]  mem_clk_mult_num_out,
  output logic      [1:0]  mem_clk_mult_den_out,
  output logic             platform_code_bad_out,
  output logic             core_code_bad_out,
  output logic             straps_valid_out,
  output logic             serdes_block_pd_out,
  output logic      [7:0]  lane_pd_out
);
  localparam int NSTRAP = 8;
  // Last synchroniser stage and the width of its fill counter
  localparam int LAST   = strap_pkg::SYNC_STAGES - 1;
  localparam int FILL_W = $clog2(strap_pkg::SYNC_STAGES + 1);
  localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(strap_pkg::SYNC_STAGES);

  logic [NSTRAP-1:0] sync_r [strap_pkg::SYNC_STAGES];
  logic [NSTRAP-1:0] raw;
  logic [3:0]        plat_code_r;
  logic [2:0]        core_code_r;
  logic              srds_r;
  logic              captured_r;
  logic [FILL_W-1:0] fill_r;
  logic [4:0]        plat_mult_r;
  logic [3:0]        core_num_r;
  logic [1:0]        core_den_r;
  logic              plat_bad_r;
  logic              core_bad_r;
  logic [7:0]        lane_pwr;
  logic [31:0]       status;

  axil_if bus ();

  // Platform strap code to multiplier, zero for reserved codes
  function automatic logic [4:0] plat_ratio(input logic [3:0] code);
    unique case (code)
      4'h0:    plat_ratio = 5'h10;
      4'h2:    plat_ratio = 5'h02;
      4'h3:    plat_ratio = 5'h03;
      4'h4:    plat_ratio = 5'h04;
      4'h5:    plat_ratio = 5'h05;
      4'h6:    plat_ratio = 5'h06;
      4'h8:    plat_ratio = 5'h08;
      4'h9:    plat_ratio = 5'h09;
      4'ha:    plat_ratio = 5'h0a;
      4'hc:    plat_ratio = 5'h0c;
      4'hd:    plat_ratio = 5'h14;
      default: plat_ratio = 5'h00;
    endcase
  endfunction

  // Core strap code to numerator and denominator, zero for reserved
  function automatic logic [5:0] core_ratio(input logic [2:0] code);
    unique case (code)
      3'h0:    core_ratio = {4'h4, 2'h1};
      3'h1:    core_ratio = {4'h9, 2'h2};
      3'h3:    core_ratio = {4'h3, 2'h2};
      3'h4:    core_ratio = {4'h2, 2'h1};
      3'h5:    core_ratio = {4'h5, 2'h2};
      3'h6:    core_ratio = {4'h3, 2'h1};
      3'h7:    core_ratio = {4'h7, 2'h2};
      default: core_ratio = {4'h0, 2'h0};
    endcase
  endfunction

  // Straps gathered in one word for the synchroniser
  assign raw = {serial_enable_strap_in,
                core_ratio_strap_bus_control_in,
                core_ratio_strap_addr_latch_in,
                core_ratio_strap_gp_line_in,
                platform_ratio_straps_in};

  // Three-stage synchroniser for the strap pins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < strap_pkg::SYNC_STAGES; i++) begin
        sync_r[i] <= '0;
      end
    end else begin
      sync_r[0] <= raw;
      for (int i = 1; i < strap_pkg::SYNC_STAGES; i++) begin
        sync_r[i] <= sync_r[i-1];
      end
    end
  end

  // Refuse a synchroniser too short to compare two settled stages
  if (strap_pkg::SYNC_STAGES < 2) begin : g_depth_check
    $error("strap synchroniser needs at least two stages");
  end

  // Count edges since release until every stage holds pin values;
  // before that the stages still hold their reset zeros
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fill_r <= '0;
    end else if (fill_r != FILL_FULL) begin
      fill_r <= fill_r + 1'b1;
    end
  end

  // One-time capture of straps after reset release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      captured_r  <= 1'b0;
      plat_code_r <= '0;
      core_code_r <= '0;
      srds_r      <= 1'b0;
    end else if (!captured_r && fill_r == FILL_FULL
                 && sync_r[LAST-1] == sync_r[LAST]) begin
      captured_r  <= 1'b1;
      plat_code_r <= sync_r[LAST][3:0];
      core_code_r <= sync_r[LAST][6:4];
      srds_r      <= sync_r[LAST][7];
    end
  end

  // Decoded ratios registered from the held codes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      plat_mult_r <= '0;
      core_num_r  <= '0;
      core_den_r  <= '0;
      plat_bad_r  <= 1'b0;
      core_bad_r  <= 1'b0;
    end else if (captured_r) begin
      plat_mult_r <= plat_ratio(plat_code_r);
      {core_num_r, core_den_r} <= core_ratio(core_code_r);
      plat_bad_r  <= (plat_ratio(plat_code_r) == 5'h00);
      core_bad_r  <= (core_ratio(core_code_r) == 6'h00);
    end
  end

  // Outputs toward the clock generators
  assign platform_mult_out     = plat_mult_r;
  assign core_mult_num_out     = core_num_r;
  assign core_mult_den_out     = core_den_r;
  // Memory clock is platform over two
  assign mem_clk_mult_num_out  = {1'b0, plat_mult_r};
  assign mem_clk_mult_den_out  = 2'h2;
  assign platform_code_bad_out = plat_bad_r;
  assign core_code_bad_out     = core_bad_r;
  assign straps_valid_out      = captured_r;
  // Block power-down only on revision 2.0 parts
  assign serdes_block_pd_out   = REV2_PART & captured_r & srds_r;
  assign lane_pd_out           = lane_pwr | {8{serdes_block_pd_out}};

  // Status word for software
  always_comb begin
    status = '0;
    status[strap_pkg::STAT_PLAT_LSB +: 4] = plat_code_r;
    status[strap_pkg::STAT_CORE_LSB +: 3] = core_code_r;
    status[strap_pkg::STAT_SRDS_BIT]      = srds_r;
    status[strap_pkg::STAT_PLAT_BAD]      = plat_bad_r;
    status[strap_pkg::STAT_CORE_BAD]      = core_bad_r;
    status[strap_pkg::STAT_CAPT_BIT]      = captured_r;
  end

  // Bus wiring to the register slave
  assign bus.awaddr  = s_axi_awaddr_in;
  assign bus.awvalid = s_axi_awvalid_in;
  assign bus.wdata   = s_axi_wdata_in;
  assign bus.wstrb   = s_axi_wstrb_in;
  assign bus.wvalid  = s_axi_wvalid_in;
  assign bus.bready  = s_axi_bready_in;
  assign bus.araddr  = s_axi_araddr_in;
  assign bus.arvalid = s_axi_arvalid_in;
  assign bus.rready  = s_axi_rready_in;
  assign s_axi_awready_out = bus.awready;
  assign s_axi_wready_out  = bus.wready;
  assign s_axi_bresp_out   = bus.bresp;
  assign s_axi_bvalid_out  = bus.bvalid;
  assign s_axi_arready_out = bus.arready;
  assign s_axi_rdata_out   = bus.rdata;
  assign s_axi_rresp_out   = bus.rresp;
  assign s_axi_rvalid_out  = bus.rvalid;

  axil_regs u_regs (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .bus          (bus),
    .status_in    (status),
    .lane_pwr_out (lane_pwr)
  );
endmodule
`default_nettype wire

// ==== verif/strap_board_model.sv ====
// Purpose: Board strap resistors on the shared local-bus pins
// Assumes: Bench picks the strapped codes before reset release
// Notes:   Every pin is always pulled, never left floating
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
  input  wire logic [3:0] plat_sel_in,
  input  wire logic [2:0] core_sel_in,
  input  wire logic       ser_sel_in,
  output logic      [3:0] plat_pins_out,
  output logic      [2:0] core_pins_out,
  output logic            ser_pin_out
);
  // Pull each strap to the chosen level; reserved codes only on request
  assign plat_pins_out = plat_sel_in;
  assign core_pins_out = core_sel_in;
  assign ser_pin_out   = ser_sel_in;
endmodule
`default_nettype wire

// ==== verif/strap_decoder_chk.sv ====
// Purpose: Port-level checks of the strap decoder
// Assumes: Straps stay still from reset release to capture
// Notes:   Ratios settle one edge after the captured flag
`timescale 1ns/1ps
`default_nettype none
module strap_decoder_chk (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [4:0] platform_mult_out,
  input  wire logic [3:0] core_mult_num_out,
  input  wire logic [1:0] core_mult_den_out,
  input  wire logic [5:0] mem_clk_mult_num_out,
  input  wire logic [1:0] mem_clk_mult_den_out,
  input  wire logic       platform_code_bad_out,
  input  wire logic       core_code_bad_out,
  input  wire logic       straps_valid_out,
  input  wire logic       serdes_block_pd_out,
  input  wire logic [7:0] lane_pd_out,
  input  wire logic       s_axi_bvalid_out,
  input  wire logic       s_axi_bready_in,
  input  wire logic [1:0] s_axi_bresp_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Captured flag seen on two edges in a row
  sequence s_settled;
    straps_valid_out ##1 straps_valid_out;
  endsequence
  property p_cap;
    $rose(rst_n_in) |-> ##[1:30] straps_valid_out;
  endproperty
  a_cap: assert property (p_cap) else $error("capture late");
  property p_rel;
    $rose(rst_n_in) |-> !straps_valid_out && platform_mult_out == 5'h00;
  endproperty
  a_rel: assert property (p_rel) else $error("stale ratio");
  property p_pre;
    !straps_valid_out |-> platform_mult_out == 5'h00 && !core_code_bad_out;
  endproperty
  a_pre: assert property (p_pre) else $error("early ratio");
  property p_hold_plat;
    s_settled |=> $stable(platform_mult_out);
  endproperty
  a_hold_plat: assert property (p_hold_plat) else $error("plat moved");
  property p_hold_core;
    s_settled |=> $stable({core_mult_num_out, core_mult_den_out});
  endproperty
  a_hold_core: assert property (p_hold_core) else $error("core moved");
  property p_mem;
    s_settled |-> mem_clk_mult_num_out == {1'b0, platform_mult_out}
      && mem_clk_mult_den_out == 2'h2;
  endproperty
  a_mem: assert property (p_mem) else $error("mem clock ratio");
  property p_pbad;
    s_settled |-> platform_code_bad_out == (platform_mult_out == 5'h00);
  endproperty
  a_pbad: assert property (p_pbad) else $error("plat flag");
  property p_cbad;
    s_settled |-> core_code_bad_out == (core_mult_den_out == 2'h0);
  endproperty
  a_cbad: assert property (p_cbad) else $error("core flag");
  property p_blk;
    serdes_block_pd_out [*2] |-> lane_pd_out == 8'hff;
  endproperty
  a_blk: assert property (p_blk) else $error("lanes not down");
  property p_bhold;
    s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule
bind strap_decoder strap_decoder_chk u_strap_decoder_chk (
  .clk_in, .rst_n_in, .platform_mult_out, .core_mult_num_out,
  .core_mult_den_out, .mem_clk_mult_num_out, .mem_clk_mult_den_out,
  .platform_code_bad_out, .core_code_bad_out, .straps_valid_out,
  .serdes_block_pd_out, .lane_pd_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_bresp_out);
`default_nettype wire

// ==== verif/strap_decoder_tb.sv ====
// Purpose: Self-checking bench of the strap decoder
// Assumes: Straps are set while reset is held
// Notes:   Each strap code needs its own reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h want %h", $time, a, e); end end
module strap_decoder_tb;
  logic        clk_in = 0, rst_n_in = 0, ser_sel = 0;
  logic [3:0]  plat_sel = 0, wstrb = 0;
  logic [2:0]  core_sel = 0;
  logic [19:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, ser_pin;
  logic        pbad, cbad, sv, bpd;
  logic [1:0]  bresp, rresp, cd, md, r;
  logic [3:0]  plat_pins, cn;
  logic [2:0]  core_pins;
  logic [4:0]  pm;
  logic [5:0]  mn;
  logic [7:0]  lpd;
  int          mismatches = 0, n_checks = 0, cyc = 0;
  // Core {num,den} per strap code, zero for the reserved one
  localparam logic [5:0] CTAB [8] = '{6'h11, 6'h26, 6'h00, 6'h0e,
                                      6'h09, 6'h16, 6'h0d, 6'h1e};
  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;
  strap_board_model u_strap_board_model (.plat_sel_in(plat_sel),
    .core_sel_in(core_sel), .ser_sel_in(ser_sel),
    .plat_pins_out(plat_pins), .core_pins_out(core_pins),
    .ser_pin_out(ser_pin));
  strap_decoder u_strap_decoder (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .platform_ratio_straps_in(plat_pins),
    .core_ratio_strap_bus_control_in(core_pins[2]),
    .core_ratio_strap_addr_latch_in(core_pins[1]),
    .core_ratio_strap_gp_line_in(core_pins[0]),
    .serial_enable_strap_in(ser_pin),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .platform_mult_out(pm),
    .core_mult_num_out(cn), .core_mult_den_out(cd),
    .mem_clk_mult_num_out(mn), .mem_clk_mult_den_out(md),
    .platform_code_bad_out(pbad), .core_code_bad_out(cbad),
    .straps_valid_out(sv), .serdes_block_pd_out(bpd), .lane_pd_out(lpd));
  // Platform multiplier per strap code, zero when reserved
  function automatic logic [4:0] pexp(input logic [3:0] c);
    case (c)
      4'h0: return 5'h10;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc: return {1'b0, c};
      4'hd: return 5'h14;
      default: return 5'h00;
    endcase
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim;
    end
  end
  // One AXI4-Lite write or read; both ends held until taken
  task automatic axi(input logic w, input logic [19:0] a,
                     input logic [31:0] wd);
    int t;
    logic ha, hw, hb;
    if (w) begin
      awaddr <= a; wdata <= wd; wstrb <= 4'hf;
      awvalid <= 1; wvalid <= 1; bready <= 1;
    end else begin
      araddr <= a; arvalid <= 1; rready <= 1;
    end
    hb = 0;
    t = 0;
    while (hb !== 1'b1 && t < 40) begin
      @(negedge clk_in);
      ha = w ? awvalid & awready : arvalid & arready;
      hw = wvalid & wready;
      hb = w ? bvalid : rvalid;
      r = w ? bresp : rresp;
      d = rdata;
      @(posedge clk_in);
      if (ha) begin awvalid <= 0; arvalid <= 0; end
      if (hw) wvalid <= 0;
      t++;
    end
    bready <= 0;
    rready <= 0;
    // Idle edge so a following call never re-drives ready in this step
    @(posedge clk_in);
    `CHK(hb, 1'b1)
  endtask
  // Reset with given straps, wait capture, judge every decoded output
  task automatic boot(input logic [3:0] p, input logic [2:0] c,
                      input logic s);
    int t;
    rst_n_in <= 0; plat_sel <= p; core_sel <= c; ser_sel <= s;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1;
    for (t = 0; t < 30 && sv !== 1'b1; t++) @(negedge clk_in);
    repeat (2) @(negedge clk_in);
    `CHK(sv, 1'b1)
    `CHK(pm, pexp(p))
    `CHK(pbad, pexp(p) == 5'h00)
    `CHK({cn, cd}, CTAB[c])
    `CHK(cbad, c == 3'h2)
    `CHK({mn, md}, {1'b0, pexp(p), 2'h2})
    `CHK(bpd, s)
    @(posedge clk_in);
  endtask
  task automatic test_plat;
    for (int i = 0; i < 16; i++) boot(i[3:0], 3'h4, 1'b0);
    $display("test_plat done");
  endtask
  task automatic test_core;
    for (int i = 0; i < 8; i++) boot(4'h4, i[2:0], 1'b0);
    $display("test_core done");
  endtask
  // Pins change after capture; outputs must not follow
  task automatic test_hold;
    boot(4'h2, 3'h1, 1'b0);
    plat_sel <= 4'hd; core_sel <= 3'h7; ser_sel <= 1;
    repeat (20) @(negedge clk_in);
    `CHK({pm, cn, bpd}, {5'h02, 4'h9, 1'b0})
    @(posedge clk_in);
    $display("test_hold done");
  endtask
  task automatic test_regs;
    boot(4'h5, 3'h6, 1'b0);
    axi(0, strap_pkg::LANE_PWR_OFFSET, 0);
    `CHK(d, 32'h0000_0000)
    axi(1, strap_pkg::LANE_PWR_OFFSET, 32'hffff_ff5a);
    `CHK(r, strap_pkg::RESP_OKAY)
    axi(0, strap_pkg::LANE_PWR_OFFSET, 0);
    `CHK(d, 32'h0000_005a)
    `CHK(lpd, 8'h5a)
    axi(1, 20'h00100, 32'h0000_0001);
    `CHK(r, strap_pkg::RESP_SLVERR)
    axi(0, 20'h00100, 0);
    `CHK({d, r}, {32'h0, strap_pkg::RESP_SLVERR})
    axi(0, strap_pkg::STRAP_STAT_OFFSET, 0);
    `CHK(d, 32'h0000_0465)
    $display("test_regs done");
  endtask
  // Serial strap powers down every lane whatever the lane field holds
  task automatic test_ser;
    boot(4'h8, 3'h0, 1'b1);
    axi(1, strap_pkg::LANE_PWR_OFFSET, 32'h0000_0000);
    `CHK(lpd, 8'hff)
    $display("test_ser done");
  endtask
  // Main sequence
  initial begin
    test_plat;
    test_core;
    test_hold;
    test_regs;
    test_ser;
    end_sim;
  end
endmodule
`default_nettype wire
